/* sdudc_key.sv */
// sdudc_key: debounces one key and gives a one-cycle pulse on each press
// assumes the key level is synchronous to ref_clk, active high
`timescale 1ns/1ps
module sdudc_key #(
    parameter int STABLE_CYC = 2_500_000
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // key
    input wire logic key_in,
    output logic key_level,
    output logic key_press
);
    import sdudc_pkg::*;

    // release is taken after a quarter window: press plus release then
    // fits 32 presses a second, where two full windows would allow only 20
    localparam int REL_CYC = (STABLE_CYC / 4 > 0) ? STABLE_CYC / 4 : 1;

    logic [CNT_W-1:0] tmr_r, tmr_nxt;
    logic lvl_r, lvl_nxt;
    logic prs_r, prs_nxt;

    // a press is accepted only after it stays put for the full window, a release after a quarter window
    always_comb begin
        tmr_nxt = tmr_r;
        lvl_nxt = lvl_r;
        prs_nxt = 1'b0;
        if (key_in == lvl_r) begin
            tmr_nxt = '0;
        end else if (tmr_r >= CNT_W'((lvl_r ? REL_CYC : STABLE_CYC) - 1)) begin
            tmr_nxt = '0;
            lvl_nxt = key_in;
            prs_nxt = key_in;
        end else begin
            tmr_nxt = tmr_r + 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            tmr_r <= '0;
            lvl_r <= 1'b0;
            prs_r <= 1'b0;
        end else begin
            tmr_r <= tmr_nxt;
            lvl_r <= lvl_nxt;
            prs_r <= prs_nxt;
        end
    end

    assign key_level = lvl_r;
    assign key_press = prs_r;
endmodule

/* sdudc_panel.sv */
// sdudc_panel: a person at the front panel, pressing keys slowly
// assumes keys are active high; key order in a mask is dir, clear, step, mode
`timescale 1ns/1ps
module sdudc_panel
    import sdudc_pkg::*;
#(
    parameter int DEB_CYC = DEBOUNCE_CYC
) (
    // clock
    input wire logic ref_clk,
    // keys
    output logic mode_key,
    output logic step_key,
    output logic clear_key,
    output logic direction_select_key
);
    initial {direction_select_key, clear_key, step_key, mode_key} = 4'h0;

    // keys only change at the falling edge, away from sampling
    task automatic hold(input logic [3:0] m);
        @(negedge ref_clk);
        {direction_select_key, clear_key, step_key, mode_key} = m;
    endtask

    task automatic tap(input logic [3:0] m, input int len);
        hold(m);
        repeat (len) @(negedge ref_clk);
        hold(4'h0);
    endtask

    // a full press: held past the debounce span, released past the quarter span
    task automatic press(input logic [3:0] m);
        tap(m, DEB_CYC + 8);
        repeat (DEB_CYC / 4 + 8) @(negedge ref_clk);
    endtask
endmodule

/* sdudc_pkg.sv */
// sdudc_pkg: constants and mode encoding for the six-digit up/down counter
// assumes a 100 MHz ref_clk; every time below is turned into cycles here
package sdudc_pkg;
    localparam int CLK_HZ = 100_000_000;
    // key debounce: least time a key must sit stable, in ms
    localparam int DEBOUNCE_MS = 25;
    localparam int DEBOUNCE_CYC = (CLK_HZ / 1000) * DEBOUNCE_MS;
    // flash rate 1 Hz: half period in ms
    localparam int FLASH_HALF_MS = 500;
    localparam int FLASH_HALF_CYC = (CLK_HZ / 1000) * FLASH_HALF_MS;
    // count step interval in ms (one count per tick while counting)
    localparam int COUNT_TICK_MS = 100;
    localparam int COUNT_TICK_CYC = (CLK_HZ / 1000) * COUNT_TICK_MS;
    // match pulse length in ms
    localparam int PULSE_MS = 100;
    localparam int PULSE_CYC = (CLK_HZ / 1000) * PULSE_MS;
    localparam int CNT_W = 27;
    localparam logic [23:0] DIGITS_ZERO = 24'h00_0000;

    typedef enum logic [8:0] {
        SDUDC_LOCK   = 9'h001,
        SDUDC_SET56  = 9'h002,
        SDUDC_SET34  = 9'h004,
        SDUDC_SET12  = 9'h008,
        SDUDC_ALLFL  = 9'h010,
        SDUDC_NORMAL = 9'h020,
        SDUDC_COUNT  = 9'h040,
        SDUDC_ALARM  = 9'h080,
        SDUDC_SPARE  = 9'h100
    } sdudc_mode_t;
endpackage

/* sdudc_top.sv */
// sdudc_top: mode sequencer, digit setting and counting for the counter
// assumes keys are active-high, synchronous levels; display driver is outside
`timescale 1ns/1ps
module sdudc_top #(
    // timing in ref_clk cycles; defaults are the silicon values, a bench may shorten them
    parameter int DEB_CYC = sdudc_pkg::DEBOUNCE_CYC,
    parameter int FLASH_CYC = sdudc_pkg::FLASH_HALF_CYC,
    parameter int TICK_CYC = sdudc_pkg::COUNT_TICK_CYC,
    parameter int PULSE_LEN = sdudc_pkg::PULSE_CYC
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // front-panel keys, high while pressed
    input wire logic mode_key,
    input wire logic step_key,
    input wire logic clear_key,
    input wire logic direction_select_key,
    // display contents: six bcd digits, digit 1 in the low nibble
    output logic [23:0] disp_digits,
    output logic [5:0] disp_blank,
    output logic disp_all_on,
    output logic dir_flag_on,
    output logic dir_is_down,
    output logic [8:0] mode_state,
    // alarm outputs
    output logic alarm_tone_out,
    output logic match_pulse_out
);
    import sdudc_pkg::*;

    // bcd increment of one two-digit pair, wrapping 99 to 00
    function automatic logic [7:0] bcd2_inc(input logic [7:0] v);
        logic [7:0] r;
        r = v;
        if (v[3:0] == 4'h9) begin
            r[3:0] = 4'h0;
            r[7:4] = (v[7:4] == 4'h9) ? 4'h0 : v[7:4] + 4'h1;
        end else begin
            r[3:0] = v[3:0] + 4'h1;
        end
        return r;
    endfunction

    // bcd step of six digits, up or down, used by the counting path
    function automatic logic [23:0] bcd6_step(input logic [23:0] v, input logic dn);
        logic [23:0] r;
        logic carry;
        r = v;
        carry = 1'b1;
        for (int i = 0; i < 6; i++) begin
            if (carry) begin
                if (!dn) begin
                    if (v[i*4 +: 4] == 4'h9) begin
                        r[i*4 +: 4] = 4'h0;
                    end else begin
                        r[i*4 +: 4] = v[i*4 +: 4] + 4'h1;
                        carry = 1'b0;
                    end
                end else begin
                    if (v[i*4 +: 4] == 4'h0) begin
                        r[i*4 +: 4] = 4'h9;
                    end else begin
                        r[i*4 +: 4] = v[i*4 +: 4] - 4'h1;
                        carry = 1'b0;
                    end
                end
            end
        end
        return r;
    endfunction

    // debounced keys; 25 ms press and quarter-window release allow 32 presses/s
    logic [3:0] key_raw;
    logic [3:0] key_lvl;
    logic [3:0] key_prs;
    assign key_raw = {direction_select_key, clear_key, step_key, mode_key};

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_key
            sdudc_key #(
                .STABLE_CYC(DEB_CYC)
            ) u_key (
                .ref_clk(ref_clk),
                .sys_rst(sys_rst),
                .key_in(key_raw[g]),
                .key_level(key_lvl[g]),
                .key_press(key_prs[g])
            );
        end
    endgenerate

    logic mode_p, step_p, clr_p, dir_p, lamp_hold;
    assign mode_p = key_prs[0];
    assign step_p = key_prs[1];
    assign clr_p = key_prs[2];
    assign dir_p = key_prs[3];
    assign lamp_hold = key_lvl[0] & key_lvl[1] & key_lvl[2];

    // state
    sdudc_mode_t st_r, st_nxt;
    logic [23:0] tgt_r, tgt_nxt;
    logic [23:0] cnt_r, cnt_nxt;
    logic down_r, down_nxt;
    logic [CNT_W-1:0] fl_tmr_r, fl_tmr_nxt;
    logic fl_ph_r, fl_ph_nxt;
    logic [CNT_W-1:0] tick_r, tick_nxt;
    logic [CNT_W-1:0] pls_r, pls_nxt;
    logic tone_r, tone_nxt;
    logic pout_r, pout_nxt;
    logic [23:0] dd_r, dd_nxt;
    logic [5:0] bl_r, bl_nxt;
    logic allon_r, allon_nxt;
    logic flag_r, flag_nxt;
    logic dn_o_r, dn_o_nxt;
    logic [8:0] mst_r, mst_nxt;

    // 1 Hz flash phase, free running
    always_comb begin
        fl_tmr_nxt = fl_tmr_r + 1'b1;
        fl_ph_nxt = fl_ph_r;
        if (fl_tmr_r >= CNT_W'(FLASH_CYC - 1)) begin
            fl_tmr_nxt = '0;
            fl_ph_nxt = ~fl_ph_r;
        end
    end

    // mode sequencer, target and running count
    always_comb begin
        st_nxt = st_r;
        tgt_nxt = tgt_r;
        cnt_nxt = cnt_r;
        down_nxt = down_r;
        tick_nxt = '0;
        pls_nxt = (pls_r != '0) ? pls_r - 1'b1 : pls_r;
        tone_nxt = tone_r;
        if (clr_p) begin
            st_nxt = SDUDC_LOCK;
            tone_nxt = 1'b0;
            pls_nxt = '0;
        end else begin
            case (st_r)
                SDUDC_LOCK: begin
                    if (mode_p) begin
                        st_nxt = SDUDC_SET56;
                    end
                end
                SDUDC_SET56: begin
                    if (step_p) begin
                        tgt_nxt[23:16] = bcd2_inc(tgt_r[23:16]);
                    end else if (mode_p) begin
                        st_nxt = SDUDC_SET34;
                    end
                end
                SDUDC_SET34: begin
                    if (step_p) begin
                        tgt_nxt[15:8] = bcd2_inc(tgt_r[15:8]);
                    end else if (mode_p) begin
                        st_nxt = SDUDC_SET12;
                    end
                end
                SDUDC_SET12: begin
                    if (step_p) begin
                        tgt_nxt[7:0] = bcd2_inc(tgt_r[7:0]);
                    end else if (mode_p) begin
                        st_nxt = SDUDC_ALLFL;
                    end
                end
                SDUDC_ALLFL: begin
                    if (dir_p) begin
                        down_nxt = ~down_r;
                    end
                    if (mode_p) begin
                        st_nxt = SDUDC_NORMAL;
                        cnt_nxt = down_r ? tgt_r : DIGITS_ZERO;
                    end
                end
                SDUDC_NORMAL: begin
                    if (mode_p) begin
                        st_nxt = SDUDC_SET56;
                    end else if (step_p) begin
                        st_nxt = SDUDC_COUNT;
                    end
                end
                SDUDC_COUNT: begin
                    if (cnt_r == (down_r ? DIGITS_ZERO : tgt_r)) begin
                        st_nxt = SDUDC_ALARM;
                        tone_nxt = 1'b1;
                        pls_nxt = CNT_W'(PULSE_LEN);
                    end else if (tick_r >= CNT_W'(TICK_CYC - 1)) begin
                        cnt_nxt = bcd6_step(cnt_r, down_r);
                    end else begin
                        tick_nxt = tick_r + 1'b1;
                    end
                end
                SDUDC_ALARM: begin
                    // mode and step presses fall through untouched
                    st_nxt = SDUDC_ALARM;
                end
                default: begin
                    st_nxt = SDUDC_LOCK;
                end
            endcase
        end
    end

    // display and output image, all registered
    always_comb begin
        dd_nxt = DIGITS_ZERO;
        bl_nxt = 6'h00;
        flag_nxt = 1'b1;
        pout_nxt = (pls_nxt != '0);
        case (st_nxt)
            SDUDC_SET56, SDUDC_SET34, SDUDC_SET12: begin
                dd_nxt = tgt_nxt;
                flag_nxt = 1'b0;
                if (fl_ph_r) begin
                    bl_nxt = (st_nxt == SDUDC_SET56) ? 6'h30 :
                             (st_nxt == SDUDC_SET34) ? 6'h0c : 6'h03;
                end
            end
            SDUDC_ALLFL: begin
                dd_nxt = tgt_nxt;
                bl_nxt = fl_ph_r ? 6'h3f : 6'h00;
            end
            SDUDC_LOCK: begin
                dd_nxt = tgt_nxt;
            end
            default: begin
                dd_nxt = cnt_nxt;
            end
        endcase
        mst_nxt = 9'(st_nxt);
        dn_o_nxt = down_nxt;
    end

    // lamp test overrides all-on, blanking, flag and tone while held; digits and direction pass through
    logic tone_o_r, tone_o_nxt;
    always_comb begin
        tone_o_nxt = tone_nxt | lamp_hold;
        allon_nxt = lamp_hold;
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            st_r <= SDUDC_LOCK;
            tgt_r <= DIGITS_ZERO;
            cnt_r <= DIGITS_ZERO;
            down_r <= 1'b0;
            fl_tmr_r <= '0;
            fl_ph_r <= 1'b0;
            tick_r <= '0;
            pls_r <= '0;
            tone_r <= 1'b0;
            tone_o_r <= 1'b0;
            pout_r <= 1'b0;
            dd_r <= DIGITS_ZERO;
            bl_r <= 6'h00;
            allon_r <= 1'b0;
            flag_r <= 1'b1;
            dn_o_r <= 1'b0;
            mst_r <= 9'h001;
        end else begin
            st_r <= st_nxt;
            tgt_r <= tgt_nxt;
            cnt_r <= cnt_nxt;
            down_r <= down_nxt;
            fl_tmr_r <= fl_tmr_nxt;
            fl_ph_r <= fl_ph_nxt;
            tick_r <= tick_nxt;
            pls_r <= pls_nxt;
            tone_r <= tone_nxt;
            tone_o_r <= tone_o_nxt;
            pout_r <= pout_nxt;
            dd_r <= dd_nxt;
            bl_r <= lamp_hold ? 6'h00 : bl_nxt;
            allon_r <= allon_nxt;
            flag_r <= flag_nxt | lamp_hold;
            dn_o_r <= dn_o_nxt;
            mst_r <= mst_nxt;
        end
    end

    assign disp_digits = dd_r;
    assign disp_blank = bl_r;
    assign disp_all_on = allon_r;
    assign dir_flag_on = flag_r;
    assign dir_is_down = dn_o_r;
    assign mode_state = mst_r;
    assign alarm_tone_out = tone_o_r;
    assign match_pulse_out = pout_r;
endmodule

/* sdudc_top_monitor.sv */
// sdudc_top_monitor: port-level assertions for the counter's mode sequencer
// assumes it is bound to sdudc_top and sees only that module's ports
`timescale 1ns/1ps
module sdudc_top_monitor
    import sdudc_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // keys
    input wire logic mode_key,
    // outputs watched
    input wire logic [23:0] disp_digits,
    input wire logic disp_all_on,
    input wire logic dir_flag_on,
    input wire logic [8:0] mode_state,
    input wire logic alarm_tone_out
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    // reset is the one cause that must not be masked by itself
    property p_reset_lock;
        disable iff (1'b0) sys_rst |=> mode_state == SDUDC_LOCK;
    endproperty
    a_reset_lock: assert property (p_reset_lock) else $error("no lock after reset");
    // three quiet cycles on the mode key rule out a pending press
    property p_lock_hold;
        mode_state == SDUDC_LOCK && !mode_key && !$past(mode_key) && !$past(mode_key, 2)
            |=> mode_state == SDUDC_LOCK;
    endproperty
    a_lock_hold: assert property (p_lock_hold) else $error("lock left without mode");
    // lamp test may light the flag, so it is excluded
    property p_flag_off;
        mode_state inside {SDUDC_SET56, SDUDC_SET34, SDUDC_SET12} && !disp_all_on
            |-> !dir_flag_on;
    endproperty
    a_flag_off: assert property (p_flag_off) else $error("flag shown while setting");
    property p_s56;
        mode_state == SDUDC_SET56 |=> mode_state inside {SDUDC_SET56, SDUDC_SET34, SDUDC_LOCK};
    endproperty
    a_s56: assert property (p_s56) else $error("bad exit from pair 5/6");
    property p_s34;
        mode_state == SDUDC_SET34 |=> mode_state inside {SDUDC_SET34, SDUDC_SET12, SDUDC_LOCK};
    endproperty
    a_s34: assert property (p_s34) else $error("bad exit from pair 3/4");
    property p_set_digits;
        mode_state == SDUDC_SET56 && $past(mode_state) == SDUDC_SET56
            |-> disp_digits[15:0] == $past(disp_digits[15:0]);
    endproperty
    a_set_digits: assert property (p_set_digits) else $error("wrong pair advanced");
    property p_alarm_hold;
        mode_state == SDUDC_ALARM |=> mode_state inside {SDUDC_ALARM, SDUDC_LOCK};
    endproperty
    a_alarm_hold: assert property (p_alarm_hold) else $error("alarm left by key");
    property p_alarm_tone;
        mode_state == SDUDC_ALARM |-> alarm_tone_out;
    endproperty
    a_alarm_tone: assert property (p_alarm_tone) else $error("alarm silent");

    // main scenarios reached
    c_set56: cover property (mode_state == SDUDC_SET56);
    c_set34: cover property (mode_state == SDUDC_SET34);
    c_lamp: cover property (disp_all_on);
endmodule

/* testbench.sv */
// testbench: walks the counter's keys through the panel model and checks
// assumes shortened timing parameters on the design; a press costs about 1.5 spans
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin n_mismatch++; \
    $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module testbench;
    import sdudc_pkg::*;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic mode_key, step_key, clear_key, direction_select_key;
    logic [23:0] disp_digits;
    logic [5:0] disp_blank;
    logic disp_all_on, dir_flag_on, dir_is_down, alarm_tone_out, match_pulse_out;
    logic [8:0] mode_state;
    int n_mismatch = 0;
    int n_checks = 0;
    int seed = 32'ha47a_48f6;
    int n12;
    logic [23:0] tgt_exp;
    // shortened timing so that the whole walk stays within a few thousand cycles
    localparam int T_DEB = 64;
    localparam int T_FLASH = 32;
    localparam int T_TICK = 8;
    localparam int T_PULSE = 32;
    // key masks in the order dir, clear, step, mode
    localparam logic [3:0] K_MODE = 4'h1;
    localparam logic [3:0] K_STEP = 4'h2;
    localparam logic [3:0] K_CLR = 4'h4;
    localparam logic [3:0] K_DIR = 4'h8;
    localparam logic [3:0] K_LAMP = 4'h7;

    always #5 ref_clk = ~ref_clk;

    sdudc_panel #(.DEB_CYC(T_DEB)) panel (.ref_clk(ref_clk), .mode_key(mode_key),
        .step_key(step_key),
        .clear_key(clear_key), .direction_select_key(direction_select_key));
    sdudc_top #(.DEB_CYC(T_DEB), .FLASH_CYC(T_FLASH), .TICK_CYC(T_TICK),
        .PULSE_LEN(T_PULSE)) DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .mode_key(mode_key),
        .step_key(step_key), .clear_key(clear_key),
        .direction_select_key(direction_select_key), .disp_digits(disp_digits),
        .disp_blank(disp_blank), .disp_all_on(disp_all_on), .dir_flag_on(dir_flag_on),
        .dir_is_down(dir_is_down), .mode_state(mode_state),
        .alarm_tone_out(alarm_tone_out), .match_pulse_out(match_pulse_out));

    // expected bcd pair after n advances
    function automatic logic [7:0] bcd2(input int n);
        return {4'(n / 10), 4'(n % 10)};
    endfunction

    // a number of full presses of the same keys
    task automatic press_n(input logic [3:0] m, input int n);
        repeat (n) panel.press(m);
    endtask

    // over one full flash period the blanked phase lasts exactly half
    task automatic blink(input logic [5:0] on_v);
        int c;
        c = 0;
        repeat (2 * T_FLASH) begin
            @(negedge ref_clk);
            if (disp_blank === on_v) c++;
        end
        `CHK("blank_on", T_FLASH, c)
    endtask

    // start counting from normal, time the run up to the match, then the pulse
    task automatic run_count(input logic [23:0] last_v, input int steps);
        int c;
        c = 0;
        panel.hold(K_STEP);
        while (mode_state !== SDUDC_COUNT && c < 2 * T_DEB) begin
            @(negedge ref_clk);
            c++;
        end
        c = 0;
        while (mode_state !== SDUDC_ALARM && c < 1000) begin
            @(negedge ref_clk);
            c++;
        end
        `CHK("count_cyc", steps * T_TICK + 1, c)
        `CHK("mode", SDUDC_ALARM, mode_state)
        `CHK("digits", last_v, disp_digits)
        `CHK("tone", 1'b1, alarm_tone_out)
        `CHK("pulse", 1'b1, match_pulse_out)
        repeat (T_PULSE - 1) @(negedge ref_clk);
        `CHK("pulse", 1'b1, match_pulse_out)
        @(negedge ref_clk);
        `CHK("pulse", 1'b0, match_pulse_out)
        panel.hold(4'h0);
        repeat (T_DEB + 8) @(negedge ref_clk);
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // watchdog: forty presses plus flash and count windows, about twice the need
    initial begin
        repeat (40 * 2 * T_DEB + 4000) @(posedge ref_clk);
        n_mismatch++;
        $display("ERROR watchdog expected done seen timeout");
        stop_test();
    end

    initial begin
        repeat (16) @(negedge ref_clk);
        sys_rst = 1'b0;
        @(negedge ref_clk);
        `CHK("mode", SDUDC_LOCK, mode_state)
        `CHK("digits", DIGITS_ZERO, disp_digits)
        `CHK("tone", 1'b0, alarm_tone_out)
        `CHK("pulse", 1'b0, match_pulse_out)
        `CHK("blank", 6'h00, disp_blank)
        `CHK("flag", 1'b1, dir_flag_on)
        $display("test reset done");
        // short random taps never reach the debounce span
        for (int i = 0; i < 8; i++)
            panel.tap(4'($random(seed)), ($random(seed) & 32'h0000_001f) + 1);
        panel.press(K_STEP);
        `CHK("mode", SDUDC_LOCK, mode_state)
        $display("test lock done");
        panel.press(K_MODE);
        `CHK("mode", SDUDC_SET56, mode_state)
        `CHK("flag", 1'b0, dir_flag_on)
        blink(6'h30);
        for (int k = 1; k <= 2; k++) begin
            panel.press(K_STEP);
            `CHK("pair56", bcd2(k), disp_digits[23:16])
            `CHK("low", 16'h0000, disp_digits[15:0])
        end
        $display("test pair56 done");
        panel.press(K_MODE);
        `CHK("mode", SDUDC_SET34, mode_state)
        blink(6'h0c);
        panel.press(K_STEP);
        `CHK("pair34", bcd2(1), disp_digits[15:8])
        `CHK("pair56", bcd2(2), disp_digits[23:16])
        $display("test pair34 done");
        panel.press(K_CLR);
        `CHK("mode", SDUDC_LOCK, mode_state)
        $display("test clear done");
        // lamp test is judged while the three keys are still down
        panel.hold(K_LAMP);
        repeat (T_DEB + 8) @(negedge ref_clk);
        `CHK("all_on", 1'b1, disp_all_on)
        `CHK("tone", 1'b1, alarm_tone_out)
        `CHK("flag", 1'b1, dir_flag_on)
        panel.hold(4'h0);
        $display("test lamp done");
        // reset again in mid-run: the target is cleared as well
        sys_rst = 1'b1;
        repeat (4) @(negedge ref_clk);
        sys_rst = 1'b0;
        @(negedge ref_clk);
        `CHK("mode", SDUDC_LOCK, mode_state)
        `CHK("digits", DIGITS_ZERO, disp_digits)
        `CHK("all_on", 1'b0, disp_all_on)
        n12 = 1 + ($random(seed) & 3);
        tgt_exp = {16'h0000, bcd2(n12)};
        press_n(K_MODE, 3);
        `CHK("mode", SDUDC_SET12, mode_state)
        blink(6'h03);
        press_n(K_STEP, n12);
        `CHK("pair12", bcd2(n12), disp_digits[7:0])
        panel.press(K_MODE);
        `CHK("mode", SDUDC_ALLFL, mode_state)
        `CHK("flag", 1'b1, dir_flag_on)
        blink(6'h3f);
        panel.press(K_DIR);
        `CHK("down", 1'b1, dir_is_down)
        panel.press(K_MODE);
        `CHK("mode", SDUDC_NORMAL, mode_state)
        `CHK("digits", tgt_exp, disp_digits)
        panel.press(K_MODE);
        `CHK("mode", SDUDC_SET56, mode_state)
        press_n(K_MODE, 4);
        `CHK("down", 1'b1, dir_is_down)
        run_count(DIGITS_ZERO, n12);
        panel.press(K_MODE);
        panel.press(K_STEP);
        `CHK("mode", SDUDC_ALARM, mode_state)
        panel.press(K_CLR);
        `CHK("mode", SDUDC_LOCK, mode_state)
        `CHK("tone", 1'b0, alarm_tone_out)
        $display("test count down done");
        press_n(K_MODE, 4);
        panel.press(K_DIR);
        `CHK("down", 1'b0, dir_is_down)
        panel.press(K_MODE);
        `CHK("digits", DIGITS_ZERO, disp_digits)
        run_count(tgt_exp, n12);
        $display("test count up done");
        stop_test();
    end
endmodule

bind sdudc_top sdudc_top_monitor mon (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .mode_key(mode_key), .disp_digits(disp_digits), .disp_all_on(disp_all_on),
    .dir_flag_on(dir_flag_on), .mode_state(mode_state), .alarm_tone_out(alarm_tone_out));
